// ---- lsp_top.sv ----
// Two-wire register slave, register bank and sink control for twelve LEDs.
`timescale 1ns/1ns
module lsp_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] addr_sel,
    input wire logic [lsp_pkg::NUM_CH-1:0] open_flags,
    input wire logic [lsp_pkg::NUM_CH-1:0] short_flags,
    output logic [lsp_pkg::NUM_CH-1:0] sink_on,
    output logic amp_enable,
    output logic [7:0] global_current_code,
    output logic [lsp_pkg::NUM_CH-1:0][7:0] channel_scale,
    output logic low_current_divide,
    output logic open_check_enable,
    output logic short_check_enable,
    output logic [1:0] detect_min_duty,
    output logic [7:0] spread_control
);
    import lsp_pkg::*;

    localparam int SW = 2 * NUM_CH + 4;

    logic [SW-1:0] s1_q;
    logic [SW-1:0] s2_q;
    logic scl;
    logic sda;
    logic scl_p_q;
    logic sda_p_q;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [1:0] strap_q;
    logic strap_ok_q;
    logic [NUM_CH-1:0] open_s;
    logic [NUM_CH-1:0] short_s;

    lsp_state_t st_q;
    lsp_state_t st_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] shreg_q;
    logic [7:0] shreg_d;
    logic [7:0] ptr_q;
    logic [7:0] ptr_d;
    logic rw_q;
    logic rw_d;
    logic sda_oe_q;
    logic sda_oe_d;
    logic sda_out_q;
    logic done;
    logic addr_hit;
    logic wr_en;
    logic soft_rst;
    logic [7:0] rd_data;

    logic [7:0] cfg_q;
    logic [7:0] gcc_q;
    logic [7:0] fdc_q;
    logic [7:0] spread_q;
    logic [7:0] scale_q [NUM_CH];
    logic [7:0] duty_q [2*NUM_CH];
    logic amp_q;
    logic [1:0] mdt_q;
    logic [NUM_CH-1:0][11:0] duty_w;
    lsp_pwm_cfg_t pcfg;

    function automatic logic in_range(input logic [7:0] idx, input logic [7:0] lo,
                                      input logic [7:0] hi);
        return (idx >= lo) && (idx <= hi);
    endfunction

    // Result registers show the live detector levels; nothing writes them.
    function automatic logic [7:0] rd_byte(input logic [7:0] idx);
        logic [7:0] r;
        r = 8'h00;
        if (idx == IDX_CFG) begin
            r = cfg_q;
        end
        if (idx == IDX_GCC) begin
            r = gcc_q;
        end
        if (in_range(idx, IDX_SCALE_LO, IDX_SCALE_HI)) begin
            r = scale_q[4'(idx - IDX_SCALE_LO)];
        end
        if (idx == IDX_FDC) begin
            r = fdc_q;
        end
        if (idx == IDX_OPEN_LO) begin
            r = {2'h0, open_s[5:0]};
        end
        if (idx == IDX_OPEN_HI) begin
            r = {2'h0, open_s[11:6]};
        end
        if (idx == IDX_SHORT_LO) begin
            r = {2'h0, short_s[5:0]};
        end
        if (idx == IDX_SHORT_HI) begin
            r = {2'h0, short_s[11:6]};
        end
        if (idx == IDX_SPREAD) begin
            r = spread_q;
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage is looked at.
    // They are kept out of reset so the strap is already in the chain when reset lifts.
    always_ff @(posedge ref_clk) begin
        s1_q <= {scl_in, sda_in, addr_sel, open_flags, short_flags};
        s2_q <= s1_q;
    end

    assign scl = s2_q[SW-1];
    assign sda = s2_q[SW-2];
    assign open_s = s2_q[2*NUM_CH-1:NUM_CH];
    assign short_s = s2_q[NUM_CH-1:0];
    assign scl_rise = scl && !scl_p_q;
    assign scl_fall = !scl && scl_p_q;
    assign start_c = scl && scl_p_q && sda_p_q && !sda;
    assign stop_c = scl && scl_p_q && !sda_p_q && sda;

    // The strap is caught once after release and then held.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            strap_q <= 2'h0;
            strap_ok_q <= 1'b0;
            sda_out_q <= 1'b0;
        end else begin
            scl_p_q <= scl;
            sda_p_q <= sda;
            sda_out_q <= 1'b0;
            if (!strap_ok_q) begin
                strap_q <= s2_q[SW-3:SW-4];
                strap_ok_q <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign done = cnt_q == 4'h8;
    assign addr_hit = shreg_q[7:1] == {SLAVE_HI, strap_q};
    assign wr_en = (st_q == ST_WDAT) && scl_fall && done;
    assign soft_rst = wr_en && (ptr_q == IDX_SWRST);
    // A process, not an assign, so a change of any register also refreshes the read byte.
    always_comb begin
        rd_data = rd_byte(ptr_q);
    end

    // Bits are taken on the rising clock edge, SDA is changed after the fall.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        shreg_d = shreg_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        sda_oe_d = sda_oe_q;
        if (stop_c) begin
            st_d = ST_IDLE;
            sda_oe_d = 1'b0;
        end else if (start_c) begin
            st_d = ST_ADDR;
            cnt_d = 4'h0;
            sda_oe_d = 1'b0;
        end else if (scl_rise) begin
            case (st_q)
                ST_ADDR, ST_REG, ST_WDAT: begin
                    shreg_d = {shreg_q[6:0], sda};
                    cnt_d = cnt_q + 4'h1;
                end
                ST_RACK: begin
                    if (sda) begin
                        st_d = ST_IDLE;
                    end else begin
                        ptr_d = ptr_q + 8'h01;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (st_q)
                ST_ADDR: begin
                    if (done && addr_hit) begin
                        st_d = ST_ACK_A;
                        sda_oe_d = 1'b1;
                        rw_d = shreg_q[0];
                    end else if (done) begin
                        st_d = ST_IDLE;
                    end
                end
                ST_ACK_A: begin
                    cnt_d = 4'h0;
                    if (rw_q) begin
                        st_d = ST_RDAT;
                        shreg_d = rd_data;
                        sda_oe_d = !rd_data[7];
                    end else begin
                        st_d = ST_REG;
                        sda_oe_d = 1'b0;
                    end
                end
                ST_REG: begin
                    if (done) begin
                        st_d = ST_ACK_R;
                        sda_oe_d = 1'b1;
                        ptr_d = shreg_q;
                    end
                end
                ST_ACK_R, ST_ACK_W: begin
                    st_d = ST_WDAT;
                    sda_oe_d = 1'b0;
                    cnt_d = 4'h0;
                end
                ST_WDAT: begin
                    if (done) begin
                        st_d = ST_ACK_W;
                        sda_oe_d = 1'b1;
                        ptr_d = ptr_q + 8'h01;
                    end
                end
                ST_RDAT: begin
                    if (cnt_q == 4'h7) begin
                        st_d = ST_RACK;
                        sda_oe_d = 1'b0;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                        shreg_d = {shreg_q[6:0], 1'b0};
                        sda_oe_d = !shreg_q[6];
                    end
                end
                ST_RACK: begin
                    st_d = ST_RDAT;
                    shreg_d = rd_data;
                    sda_oe_d = !rd_data[7];
                    cnt_d = 4'h0;
                end
                default: begin
                    st_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            shreg_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            shreg_q <= shreg_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            sda_oe_q <= sda_oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bank. Indices 26h to 55h accept a write and keep nothing.
    always_ff @(posedge ref_clk) begin
        if (rst || soft_rst) begin
            cfg_q <= CFG_RST;
            gcc_q <= ZERO_RST;
            fdc_q <= ZERO_RST;
            spread_q <= ZERO_RST;
            for (int i = 0; i < NUM_CH; i++) begin
                scale_q[i] <= ZERO_RST;
            end
            for (int i = 0; i < 2 * NUM_CH; i++) begin
                duty_q[i] <= ZERO_RST;
            end
        end else if (wr_en) begin
            if (ptr_q == IDX_CFG) begin
                cfg_q <= (shreg_q & CFG_WMASK) | (CFG_RST & ~CFG_WMASK);
            end
            if (ptr_q == IDX_GCC) begin
                gcc_q <= shreg_q;
            end
            if (ptr_q == IDX_FDC) begin
                fdc_q <= shreg_q;
            end
            if (ptr_q == IDX_SPREAD) begin
                spread_q <= shreg_q;
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (ptr_q == IDX_SCALE_LO + 8'(i)) begin
                    scale_q[i] <= shreg_q;
                end
            end
            for (int i = 0; i < 2 * NUM_CH; i++) begin
                if (ptr_q == IDX_DUTY_LO + 8'(i)) begin
                    duty_q[i] <= i[0] ? (shreg_q & DUTY_HI_MASK) : shreg_q;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            duty_w[i] = {duty_q[2*i+1][3:0], duty_q[2*i]};
            channel_scale[i] = scale_q[i];
        end
    end

    assign pcfg = {cfg_q[CFG_RUN], cfg_q[CFG_STAGGER], cfg_q[CFG_RES8],
                   fdc_q[FDC_FREQ_LSB +: 3]};

    lsp_pwm u_pwm (
        .ref_clk(ref_clk),
        .rst(rst),
        .cfg(pcfg),
        .duty(duty_w),
        .sink_on(sink_on)
    );

    // The 12 percent detect floor only exists in 8-bit mode; 12-bit falls to 6.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            amp_q <= 1'b0;
            mdt_q <= 2'h0;
        end else begin
            amp_q <= cfg_q[CFG_RUN] && !(cfg_q[CFG_AMPOFF] && (sink_on == '0));
            mdt_q <= (fdc_q[FDC_MDT_LSB+1] && !cfg_q[CFG_RES8]) ?
                2'h0 : fdc_q[FDC_MDT_LSB +: 2];
        end
    end

    assign sda_out = sda_out_q;
    assign sda_oe = sda_oe_q;
    assign amp_enable = amp_q;
    assign global_current_code = gcc_q;
    assign low_current_divide = fdc_q[FDC_LOWCUR];
    assign open_check_enable = fdc_q[FDC_OPEN];
    assign short_check_enable = fdc_q[FDC_SHORT];
    assign detect_min_duty = mdt_q;
    assign spread_control = spread_q;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk);
    endclocking

    property p_cfg_reset;
        rst |=> (cfg_q == CFG_RST) && (gcc_q == ZERO_RST) && (fdc_q == ZERO_RST);
    endproperty
    a_cfg_reset: assert property (p_cfg_reset) else $error("reset values wrong");

    property p_soft_reset;
        disable iff (rst) soft_rst |=> (cfg_q == CFG_RST) && (scale_q[0] == ZERO_RST);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("soft reset failed");

    property p_ptr_inc;
        disable iff (rst) wr_en |=> ptr_q == $past(ptr_q) + 8'h01;
    endproperty
    a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");

    sequence s_addr_done;
        (st_q == ST_ADDR) && scl_fall && done;
    endsequence

    property p_addr_hit;
        disable iff (rst) s_addr_done |=> (st_q == ST_ACK_A) == $past(addr_hit);
    endproperty
    a_addr_hit: assert property (p_addr_hit) else $error("address decode wrong");

    property p_read_load;
        disable iff (rst) ((st_q == ST_ACK_A) && rw_q && scl_fall) |=>
            (shreg_q == $past(rd_data)) && (sda_oe_q == !$past(rd_data[7]));
    endproperty
    a_read_load: assert property (p_read_load) else $error("read byte wrong");

    property p_duty_wo;
        disable iff (rst) in_range(ptr_q, IDX_DUTY_LO, IDX_DUTY_END) |-> rd_data == 8'h00;
    endproperty
    a_duty_wo: assert property (p_duty_wo) else $error("duty readable");

    property p_unused_zero;
        disable iff (rst) (ptr_q == IDX_OPEN_LO) |-> rd_data[7:6] == 2'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

    property p_shutdown;
        disable iff (rst) !cfg_q[CFG_RUN] [*2] |-> sink_on == '0;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("output in shutdown");

    property p_amp_on;
        disable iff (rst) (cfg_q[CFG_RUN] && !cfg_q[CFG_AMPOFF]) |=> amp_enable;
    endproperty
    a_amp_on: assert property (p_amp_on) else $error("amplifier off");
endmodule

// ---- lsp_pkg.sv ----
// Package of constants, types and states for the LED sink dimming block.
package lsp_pkg;
    localparam int NUM_CH = 12;
    localparam logic [7:0] IDX_CFG = 8'h00;
    localparam logic [7:0] IDX_GCC = 8'h01;
    localparam logic [7:0] IDX_SCALE_LO = 8'h02;
    localparam logic [7:0] IDX_SCALE_HI = 8'h0D;
    localparam logic [7:0] IDX_DUTY_LO = 8'h0E;
    localparam logic [7:0] IDX_DUTY_HI = 8'h25;
    localparam logic [7:0] IDX_DUTY_END = 8'h55;
    localparam logic [7:0] IDX_FDC = 8'h61;
    localparam logic [7:0] IDX_OPEN_LO = 8'h62;
    localparam logic [7:0] IDX_OPEN_HI = 8'h63;
    localparam logic [7:0] IDX_SHORT_LO = 8'h68;
    localparam logic [7:0] IDX_SHORT_HI = 8'h69;
    localparam logic [7:0] IDX_SPREAD = 8'h6E;
    localparam logic [7:0] IDX_SWRST = 8'h7F;
    localparam logic [7:0] CFG_RST = 8'h32;
    localparam logic [7:0] CFG_WMASK = 8'h47;
    localparam logic [7:0] ZERO_RST = 8'h00;
    localparam logic [7:0] DUTY_HI_MASK = 8'h0F;
    localparam int CFG_RUN = 0;
    localparam int CFG_STAGGER = 1;
    localparam int CFG_AMPOFF = 2;
    localparam int CFG_RES8 = 6;
    localparam int FDC_OPEN = 0;
    localparam int FDC_SHORT = 1;
    localparam int FDC_MDT_LSB = 2;
    localparam int FDC_FREQ_LSB = 4;
    localparam int FDC_LOWCUR = 7;
    localparam logic [4:0] SLAVE_HI = 5'h11;
    localparam int CLK_HZ = 100_000_000;
    localparam int BASE_FREQ_HZ = 64_000;
    localparam int STEPS8 = 256;
    localparam logic [9:0] STEP_DIV_CYC = 10'(CLK_HZ / (BASE_FREQ_HZ * STEPS8));
    localparam logic [11:0] TOP8 = 12'h0FF;
    localparam logic [11:0] TOP12 = 12'hFFF;
    localparam logic [11:0] HALF8 = 12'h080;
    localparam logic [11:0] HALF12 = 12'h800;
    localparam logic [2:0] FREQ12_KNEE = 3'h4;

    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_ADDR = 9'h002,
        ST_ACK_A = 9'h004,
        ST_REG = 9'h008,
        ST_ACK_R = 9'h010,
        ST_WDAT = 9'h020,
        ST_ACK_W = 9'h040,
        ST_RDAT = 9'h080,
        ST_RACK = 9'h100
    } lsp_state_t;

    typedef struct packed {
        logic run;
        logic stagger;
        logic res8;
        logic [2:0] freq;
    } lsp_pwm_cfg_t;
endpackage

// ---- lsp_pwm.sv ----
// Period counter and duty comparators for the twelve sink enables.
`timescale 1ns/1ns
module lsp_pwm (
    input wire logic ref_clk,
    input wire logic rst,
    input wire lsp_pkg::lsp_pwm_cfg_t cfg,
    input wire logic [lsp_pkg::NUM_CH-1:0][11:0] duty,
    output logic [lsp_pkg::NUM_CH-1:0] sink_on
);
    import lsp_pkg::*;

    logic [9:0] div_q;
    logic [11:0] pos_q;
    logic [NUM_CH-1:0][11:0] lat_q;
    logic [NUM_CH-1:0][11:0] lim_w;
    logic res8_q;
    logic stag_q;
    logic [NUM_CH-1:0] on_q;
    logic [2:0] shift_w;
    logic [9:0] div_top;
    logic [11:0] top_w;
    logic [11:0] half_w;
    logic step;
    logic wrap;

    // Codes above the knee slow both modes; below it 12-bit stays at 4 kHz.
    assign shift_w = cfg.res8 ? cfg.freq :
        ((cfg.freq > FREQ12_KNEE) ? cfg.freq - FREQ12_KNEE : 3'h0);
    assign div_top = (STEP_DIV_CYC << shift_w) - 10'h001;
    assign step = div_q >= div_top;
    assign top_w = res8_q ? TOP8 : TOP12;
    assign half_w = res8_q ? HALF8 : HALF12;
    assign wrap = step && (pos_q >= top_w);
    assign sink_on = on_q;

    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            lim_w[i] = res8_q ? {4'h0, lat_q[i][7:0]} : lat_q[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Parked at the top while stopped, so the first step after run latches.
    always_ff @(posedge ref_clk) begin
        if (rst || !cfg.run) begin
            div_q <= 10'h000;
            pos_q <= TOP12;
            lat_q <= '0;
            res8_q <= 1'b0;
            stag_q <= 1'b0;
        end else if (step) begin
            div_q <= 10'h000;
            if (wrap) begin
                pos_q <= 12'h000;
                lat_q <= duty;
                res8_q <= cfg.res8;
                stag_q <= cfg.stagger;
            end else begin
                pos_q <= pos_q + 12'h001;
            end
        end else begin
            div_q <= div_q + 10'h001;
        end
    end

    // Even-numbered outputs see the count shifted by half a period.
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NUM_CH; i++) begin
            if (rst || !cfg.run) begin
                on_q[i] <= 1'b0;
            end else if (stag_q && i[0]) begin
                on_q[i] <= (pos_q ^ half_w) < lim_w[i];
            end else begin
                on_q[i] <= pos_q < lim_w[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_latch_at_wrap;
        @(posedge ref_clk) disable iff (rst) (cfg.run && wrap) |=> lat_q == $past(duty);
    endproperty
    a_latch_at_wrap: assert property (p_latch_at_wrap) else $error("duty not latched");

    property p_out1_duty;
        @(posedge ref_clk) disable iff (rst)
            (cfg.run && $past(cfg.run)) |-> sink_on[0] == ($past(pos_q) < $past(lim_w[0]));
    endproperty
    a_out1_duty: assert property (p_out1_duty) else $error("out1 duty wrong");

    property p_stagger;
        @(posedge ref_clk) disable iff (rst)
            (cfg.run && stag_q) ##1 cfg.run |->
            sink_on[1] == (($past(pos_q) ^ $past(half_w)) < $past(lim_w[1]));
    endproperty
    a_stagger: assert property (p_stagger) else $error("out2 phase wrong");
endmodule

// ---- lsp_mst.sv ----
// Two-wire bus master model that drives the clock and data lines.
`timescale 1ns/1ns
module lsp_mst (
    input wire logic ref_clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic cy(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Data moves only while the clock is low, so it is never mistaken for a start or stop.
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        cy(4);
        scl = 1'b1;
        cy(4);
        r = sda;
        cy(4);
        scl = 1'b0;
        cy(4);
    endtask
    task automatic xb(input logic [7:0] d, input logic am, output logic [7:0] q,
                      output logic ak);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(am, ak);
    endtask
    task automatic start();
        sda_low = 1'b0;
        cy(4);
        scl = 1'b1;
        cy(8);
        sda_low = 1'b1;
        cy(8);
        scl = 1'b0;
        cy(4);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        cy(4);
        scl = 1'b1;
        cy(8);
        sda_low = 1'b0;
        cy(8);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] i, input logic [7:0] d[$],
                      output logic nak);
        logic [7:0] q;
        logic k;
        start();
        xb({a, 1'b0}, 1'b1, q, nak);
        xb(i, 1'b1, q, k);
        foreach (d[j]) begin
            xb(d[j], 1'b1, q, k);
        end
        stop();
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] i, output logic [7:0] q0,
                      output logic [7:0] q1);
        logic k;
        start();
        xb({a, 1'b0}, 1'b1, q0, k);
        xb(i, 1'b1, q0, k);
        start();
        xb({a, 1'b1}, 1'b1, q0, k);
        xb(8'hFF, 1'b0, q0, k);
        xb(8'hFF, 1'b1, q1, k);
        stop();
    endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the LED sink dimming block.
`timescale 1ns/1ns
module tb_top;
    import lsp_pkg::*;
    localparam logic [6:0] DEV = 7'h46;
    localparam logic [6:0] BAD = 7'h42;
    logic ref_clk, rst, scl, sda_low, sda_out, sda_oe, nak, amp_enable;
    logic low_current_divide, open_check_enable, short_check_enable;
    logic [1:0] addr_sel, detect_min_duty;
    logic [7:0] global_current_code, spread_control, q0, q1;
    logic [NUM_CH-1:0] open_flags, short_flags, sink_on;
    logic [NUM_CH-1:0][7:0] channel_scale;
    wire sda = (sda_oe ? sda_out : 1'b1) & !sda_low;
    int failures, checks_done, cyc, on, both;
    lsp_mst u_lsp_mst (.ref_clk, .sda, .scl, .sda_low);
    lsp_top u_lsp_top (.ref_clk, .rst, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
        .addr_sel, .open_flags, .short_flags, .sink_on, .amp_enable, .global_current_code,
        .channel_scale, .low_current_divide, .open_check_enable, .short_check_enable,
        .detect_min_duty, .spread_control);
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cb(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cn(input string n, input int e, input int g);
        checks_done++;
        if (g != e) begin
            failures++;
            $display("wrong value %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic w(input logic [7:0] i, input logic [7:0] d[$]);
        u_lsp_mst.wr(DEV, i, d, nak);
    endtask
    task automatic r(input logic [7:0] i);
        u_lsp_mst.rd(DEV, i, q0, q1);
    endtask
    // Counting over whole periods makes the result independent of phase.
    task automatic pw(input int n);
        on = 0;
        both = 0;
        repeat (n) begin
            @(posedge ref_clk);
            #1;
            on += int'(sink_on[0]);
            both += int'(sink_on[0] & sink_on[1]);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        addr_sel = 2'b10;
        open_flags = 12'h0A5;
        short_flags = 12'h5C3;
        repeat (4) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        u_lsp_mst.cy(6);
        r(IDX_CFG);
        cb("cfg", 8'h32, q0);
        cb("gcc", 8'h00, q1);
        cb("sinks", 8'h00, {7'h00, |sink_on});
        cb("spr0", 8'h00, spread_control);
        u_lsp_mst.wr(BAD, IDX_GCC, {8'h55}, nak);
        cb("nak", 8'h01, {7'h00, nak});
        w(IDX_GCC, {8'h40, 8'h11, 8'h22});
        cb("gcc", 8'h40, global_current_code);
        cb("scale0", 8'h11, channel_scale[0]);
        cb("scale1", 8'h22, channel_scale[1]);
        r(IDX_GCC);
        cb("rd0", 8'h40, q0);
        cb("rd1", 8'h11, q1);
        w(IDX_DUTY_LO, {8'h77});
        r(IDX_DUTY_LO);
        cb("duty", 8'h00, q0);
        w(IDX_OPEN_LO, {8'hFF});
        r(IDX_OPEN_LO);
        cb("open0", 8'h25, q0);
        cb("open1", 8'h02, q1);
        w(IDX_FDC, {8'h87});
        cb("lowcur", 8'h01, {7'h00, low_current_divide});
        cb("det", 8'h03, {6'h00, short_check_enable, open_check_enable});
        cb("mdt", 8'h01, {6'h00, detect_min_duty});
        w(IDX_FDC, {8'h0C});
        cb("mdt12", 8'h00, {6'h00, detect_min_duty});
        w(IDX_CFG, {8'hFF});
        r(IDX_CFG);
        cb("cfgmask", 8'h77, q0);
        w(IDX_CFG, {8'h40});
        w(IDX_DUTY_LO, {8'h40, 8'h00, 8'h40});
        w(IDX_CFG, {8'h43});
        pw(1536);
        cn("on8", 384, on);
        cn("stag", 0, both);
        w(IDX_CFG, {8'h41});
        u_lsp_mst.cy(1600);
        pw(1536);
        cn("same", 384, both);
        cb("amp", 8'h01, {7'h00, amp_enable});
        w(IDX_FDC, {8'h10});
        u_lsp_mst.cy(3200);
        pw(3072);
        cn("freq8", 768, on);
        w(IDX_CFG, {8'h04});
        u_lsp_mst.cy(4);
        cb("off", 8'h00, {7'h00, |sink_on});
        cb("ampoff", 8'h00, {7'h00, amp_enable});
        w(IDX_DUTY_LO, {8'h00, 8'h01});
        w(IDX_CFG, {8'h01});
        pw(24576);
        cn("on12", 1536, on);
        cn("out2", 384, both);
        w(IDX_SPREAD, {8'h5A});
        cb("spread", 8'h5A, spread_control);
        w(IDX_SWRST, {8'h00});
        r(IDX_CFG);
        cb("swcfg", 8'h32, q0);
        cb("swgcc", 8'h00, global_current_code);
        cb("swspr", 8'h00, spread_control);
        final_report();
    end
endmodule
